// ===== core/e1hmc_params.svh
// e1hmc_params.svh: offsets, field positions, reset values and frame counts
// of the E1 hardware-mode control block.
// assumes: included by bare name from the package only; the design modules see its macros through it.
`ifndef E1HMC_PARAMS_SVH
`define E1HMC_PARAMS_SVH

// register word indices; the byte address is four times the index
`define E1HMC_IDX_TX_INSERT   4'h0
`define E1HMC_IDX_TX_EXTRA    4'h1
`define E1HMC_IDX_COMMON      4'h2
`define E1HMC_IDX_TX_CFG      4'h3
`define E1HMC_IDX_RX_CFG      4'h4
`define E1HMC_IDX_STATUS      4'h5
`define E1HMC_IDX_BV_CNT      4'h6
`define E1HMC_IDX_CRC_CNT     4'h7
`define E1HMC_IDX_FE_CNT      4'h8
`define E1HMC_IDX_LAST        4'h8

// strap-driven control bit positions
`define E1HMC_BIT_FAR_ALARM   5
`define E1HMC_BIT_FAR_MF      2
`define E1HMC_BIT_TX_HDB3     5
`define E1HMC_BIT_RX_HDB3     4
`define E1HMC_BIT_TX_CRC4     3
`define E1HMC_BIT_RX_CRC4     2
`define E1HMC_BIT_CAS_OFF     5

// status register fields
`define E1HMC_ST_SYNC_LOST    0

// reset values
`define E1HMC_RST_CTRL        8'h00
`define E1HMC_RST_SYNC_LOST   1'b1

// serial frame: 16 bits, command byte then data byte
`define E1HMC_CMD_LAST        4'h7
`define E1HMC_FRAME_LAST      4'hF
`define E1HMC_RD_FLAG         15

`endif

// ===== core/e1hmc_pkg.sv
// e1hmc_pkg: types shared by the E1 hardware-mode control block.
// assumes: e1hmc_params.svh is on the include path.
package e1hmc_pkg;
    `include "e1hmc_params.svh"

    typedef struct packed {
        logic [7:0] tx_insert;
        logic [7:0] tx_extra;
        logic [7:0] common;
        logic [7:0] tx_cfg;
        logic [7:0] rx_cfg;
    } e1hmc_ctrl_t;

    typedef struct packed {
        logic far_alarm_send_strap;
        logic far_multiframe_alarm_strap;
        logic line_code_strap;
        logic crc4_strap;
        logic cas_off_strap;
    } e1hmc_strap_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } e1hmc_wr_t;

    typedef enum logic [1:0] {
        E1HMC_WB_IDLE = 2'b01,
        E1HMC_WB_ACK  = 2'b10
    } e1hmc_wb_state_t;
endpackage : e1hmc_pkg

// ===== core/e1hmc_serial.sv
// e1hmc_serial: serial control port shift engine on the serial clock.
// assumes: frames are exactly 16 bits with cs_n low; rd_data and the words
// it hands over stay still between frames, so the other domain may sample.
module e1hmc_serial
    import e1hmc_pkg::*;
(
    // serial clock domain
    input  wire logic        sclk,
    input  wire logic        srst_n,
    input  wire logic        port_en,
    // serial pins
    input  wire logic        cs_n,
    input  wire logic        serial_in_line,
    output logic             serial_out_line,
    output logic             serial_out_oe,
    // crossing toward the register domain
    input  wire logic [7:0]  rd_data,
    output e1hmc_pkg::e1hmc_wr_t wr_word,
    output logic             wr_tgl,
    output logic [3:0]       rd_addr,
    output logic             rd_tgl
);
    logic [3:0]  cnt;
    logic [15:0] shift_in;
    logic [7:0]  shift_out;
    logic [3:0]  next_cnt;
    logic [15:0] next_shift_in;
    logic [7:0]  next_shift_out;
    logic        next_sdo;
    logic        next_oe;
    e1hmc_wr_t   next_wr_word;
    logic        next_wr_tgl;
    logic [3:0]  next_rd_addr;
    logic        next_rd_tgl;
    logic [15:0] word;

    always_comb begin
        word           = {shift_in[14:0], serial_in_line};
        next_cnt       = cnt;
        next_shift_in  = shift_in;
        next_shift_out = shift_out;
        next_sdo       = 1'b0;
        next_oe        = 1'b0;
        next_wr_word   = wr_word;
        next_wr_tgl    = wr_tgl;
        next_rd_addr   = rd_addr;
        next_rd_tgl    = rd_tgl;
        if (!port_en || cs_n) begin
            next_cnt = 4'h0;
        end else begin
            // input sampled on the rising edge, host changes it while low
            next_shift_in = word;
            next_cnt      = cnt + 4'h1;
            if (cnt == `E1HMC_CMD_LAST) begin
                next_sdo       = rd_data[7];
                next_shift_out = {rd_data[6:0], 1'b0};
                next_oe        = 1'b1;
            end else if (cnt > `E1HMC_CMD_LAST && cnt < `E1HMC_FRAME_LAST) begin
                next_sdo       = shift_out[7];
                next_shift_out = {shift_out[6:0], 1'b0};
                next_oe        = 1'b1;
            end
            if (cnt == `E1HMC_FRAME_LAST) begin
                // a read frame only sets the address shifted out next frame
                if (word[`E1HMC_RD_FLAG]) begin
                    next_rd_addr = word[11:8];
                    next_rd_tgl  = ~rd_tgl;
                end else begin
                    next_wr_word = '{addr: word[11:8], data: word[7:0]};
                    next_wr_tgl  = ~wr_tgl;
                end
            end
        end
    end

    always_ff @(posedge sclk or negedge srst_n) begin
        if (!srst_n) begin
            cnt             <= 4'h0;
            shift_in        <= 16'h0000;
            shift_out       <= 8'h00;
            serial_out_line <= 1'b0;
            serial_out_oe   <= 1'b0;
            wr_word         <= '0;
            wr_tgl          <= 1'b0;
            rd_addr         <= 4'h0;
            rd_tgl          <= 1'b0;
        end else begin
            cnt             <= next_cnt;
            shift_in        <= next_shift_in;
            shift_out       <= next_shift_out;
            serial_out_line <= next_sdo;
            serial_out_oe   <= next_oe;
            wr_word         <= next_wr_word;
            wr_tgl          <= next_wr_tgl;
            rd_addr         <= next_rd_addr;
            rd_tgl          <= next_rd_tgl;
        end
    end
endmodule : e1hmc_serial

// ===== core/e1hmc_sync.sv
// e1hmc_sync: two-flop level synchroniser, also used as a reset release.
// assumes: d is either a level from another domain or a constant one.
module e1hmc_sync #(
    parameter int              WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : e1hmc_sync

// ===== core/e1hmc_top.sv
// e1hmc_top: control register bank of an E1 framer with a pin-strapped
// hardware mode, reached over classic Wishbone and a serial control port.
// assumes: straps and the port select are static pins; resync_busy comes
// from the framer on clk; sclk is the serial port's own clock.
module e1hmc_top
    import e1hmc_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // wishbone slave
    input  wire logic                  wb_cyc,
    input  wire logic                  wb_stb,
    input  wire logic                  wb_we,
    input  wire logic [7:0]            wb_adr,
    input  wire logic [3:0]            wb_sel,
    input  wire logic [31:0]           wb_dat_w,
    output logic      [31:0]           wb_dat_r,
    output logic                       wb_ack,
    // serial control port
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  serial_in_line,
    output logic                       serial_out_line,
    output logic                       serial_out_oe,
    // mode pins
    input  wire logic                  host_port_select_n,
    input  e1hmc_pkg::e1hmc_strap_t    straps,
    // framer side
    input  wire logic                  resync_busy,
    output e1hmc_pkg::e1hmc_ctrl_t     ctrl,
    output logic                       rx_sync_lost,
    output logic                       hw_mode
);
    import e1hmc_pkg::*;

    // reset release and pin synchronisers
    logic            rst_sync_n;
    logic            srst_n;
    logic            port_en;
    logic [7:0]      pin_s;
    logic            sps_s;
    e1hmc_strap_t    strap_s;
    logic            wr_tgl_s;
    logic            rd_tgl_s;

    // serial engine crossing words
    e1hmc_wr_t       ser_wr_word;
    logic            ser_wr_tgl;
    logic [3:0]      ser_rd_addr;
    logic            ser_rd_tgl;
    logic [7:0]      rd_snap;
    logic [7:0]      next_rd_snap;

    // crossing edge detection
    logic            wr_tgl_q;
    logic            rd_tgl_q;
    logic            ser_wr;
    logic            ser_rd;

    // register bank
    e1hmc_ctrl_t     next_ctrl;
    logic            next_hw_mode;
    logic            next_sync_lost;
    logic            hw_now;
    logic            hw_enter;
    logic [7:0]      status;
    logic [7:0]      err_cnt [0:2];
    logic [7:0]      next_err_cnt [0:2];

    // wishbone
    e1hmc_wb_state_t wb_state;
    e1hmc_wb_state_t next_wb_state;
    logic [31:0]     next_dat_r;
    logic            next_ack;
    logic [3:0]      wb_idx;
    logic            wb_mapped;
    logic            wb_wr;

    function automatic logic [7:0] read_reg(
        input logic [3:0]  idx,
        input e1hmc_ctrl_t c,
        input logic [7:0]  st,
        input logic [7:0]  bv,
        input logic [7:0]  crc,
        input logic [7:0]  fe
    );
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `E1HMC_IDX_TX_INSERT: v = c.tx_insert;
            `E1HMC_IDX_TX_EXTRA:  v = c.tx_extra;
            `E1HMC_IDX_COMMON:    v = c.common;
            `E1HMC_IDX_TX_CFG:    v = c.tx_cfg;
            `E1HMC_IDX_RX_CFG:    v = c.rx_cfg;
            `E1HMC_IDX_STATUS:    v = st;
            `E1HMC_IDX_BV_CNT:    v = bv;
            `E1HMC_IDX_CRC_CNT:   v = crc;
            `E1HMC_IDX_FE_CNT:    v = fe;
            default:              v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    function automatic e1hmc_ctrl_t put_ctrl(
        input e1hmc_ctrl_t c,
        input logic [3:0]  idx,
        input logic [7:0]  d
    );
        e1hmc_ctrl_t r;
        r = c;
        case (idx)
            `E1HMC_IDX_TX_INSERT: r.tx_insert = d;
            `E1HMC_IDX_TX_EXTRA:  r.tx_extra  = d;
            `E1HMC_IDX_COMMON:    r.common    = d;
            `E1HMC_IDX_TX_CFG:    r.tx_cfg    = d;
            `E1HMC_IDX_RX_CFG:    r.rx_cfg    = d;
            default:              r = c;
        endcase
        return r;
    endfunction : put_ctrl

    e1hmc_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_clk (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (rst_sync_n)
    );

    e1hmc_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sclk (
        .clk   (sclk),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (srst_n)
    );

    // port stays disabled until the select level has crossed
    e1hmc_sync #(.WIDTH(1), .INIT(1'b0)) u_port_en (
        .clk   (sclk),
        .rst_n (srst_n),
        .d     (host_port_select_n),
        .q     (port_en)
    );

    // select resets high so straps never leak in before it has crossed
    e1hmc_sync #(.WIDTH(8), .INIT(8'h80)) u_pins (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     ({host_port_select_n, straps, ser_wr_tgl, ser_rd_tgl}),
        .q     (pin_s)
    );

    assign sps_s    = pin_s[7];
    assign strap_s  = pin_s[6:2];
    assign wr_tgl_s = pin_s[1];
    assign rd_tgl_s = pin_s[0];

    e1hmc_serial u_serial (
        .sclk            (sclk),
        .srst_n          (srst_n),
        .port_en         (port_en),
        .cs_n            (cs_n),
        .serial_in_line  (serial_in_line),
        .serial_out_line (serial_out_line),
        .serial_out_oe   (serial_out_oe),
        .rd_data         (rd_snap),
        .wr_word         (ser_wr_word),
        .wr_tgl          (ser_wr_tgl),
        .rd_addr         (ser_rd_addr),
        .rd_tgl          (ser_rd_tgl)
    );

    // serial requests: word fields are still when their toggle arrives
    assign ser_wr   = (wr_tgl_s ^ wr_tgl_q) & ~hw_now;
    assign ser_rd   = (rd_tgl_s ^ rd_tgl_q) & ~hw_now;
    assign hw_now   = ~sps_s;
    assign hw_enter = hw_now & ~hw_mode;
    // status unreadable in hardware mode; the alarm pin carries it
    assign status   = hw_now ? 8'h00 : {7'h00, rx_sync_lost};

    always_comb begin
        next_rd_snap = rd_snap;
        if (ser_rd) begin
            next_rd_snap = read_reg(ser_rd_addr, ctrl, status,
                                    err_cnt[0], err_cnt[1], err_cnt[2]);
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_tgl_q <= 1'b0;
            rd_tgl_q <= 1'b0;
            rd_snap  <= 8'h00;
        end else begin
            wr_tgl_q <= wr_tgl_s;
            rd_tgl_q <= rd_tgl_s;
            rd_snap  <= next_rd_snap;
        end
    end

    // wishbone: ack one cycle after the request is seen, write at ack edge
    assign wb_idx    = wb_adr[5:2];
    assign wb_mapped = (wb_adr[7:6] == 2'b00) && (wb_idx <= `E1HMC_IDX_LAST);
    assign wb_wr     = (wb_state == E1HMC_WB_ACK) && wb_we && wb_sel[0] && wb_mapped;

    always_comb begin
        next_wb_state = wb_state;
        next_dat_r    = wb_dat_r;
        next_ack      = 1'b0;
        case (wb_state)
            E1HMC_WB_IDLE: begin
                if (wb_cyc && wb_stb) begin
                    next_wb_state = E1HMC_WB_ACK;
                    next_ack      = 1'b1;
                    next_dat_r    = 32'h0000_0000;
                    if (!wb_we && wb_mapped) begin
                        next_dat_r[7:0] = read_reg(wb_idx, ctrl, status,
                                                   err_cnt[0], err_cnt[1], err_cnt[2]);
                    end
                end
            end
            E1HMC_WB_ACK: begin
                next_wb_state = E1HMC_WB_IDLE;
            end
            default: begin
                next_wb_state = E1HMC_WB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wb_state <= E1HMC_WB_IDLE;
            wb_dat_r <= 32'h0000_0000;
            wb_ack   <= 1'b0;
        end else begin
            wb_state <= next_wb_state;
            wb_dat_r <= next_dat_r;
            wb_ack   <= next_ack;
        end
    end

    // control bank: bus write, then serial write, then mode entry and straps
    always_comb begin
        next_ctrl      = ctrl;
        next_hw_mode   = hw_now;
        next_sync_lost = resync_busy;
        if (!hw_now && wb_wr) begin
            next_ctrl = put_ctrl(next_ctrl, wb_idx, wb_dat_w[7:0]);
        end
        if (ser_wr) begin
            next_ctrl = put_ctrl(next_ctrl, ser_wr_word.addr, ser_wr_word.data);
        end
        if (hw_enter) begin
            next_ctrl = '0;
        end
        if (hw_now) begin
            // straps are re-copied every cycle so pin changes take effect
            next_ctrl.tx_insert[`E1HMC_BIT_FAR_ALARM] = strap_s.far_alarm_send_strap;
            next_ctrl.tx_extra[`E1HMC_BIT_FAR_MF] = strap_s.far_multiframe_alarm_strap;
            next_ctrl.common[`E1HMC_BIT_TX_HDB3] = strap_s.line_code_strap;
            next_ctrl.common[`E1HMC_BIT_RX_HDB3] = strap_s.line_code_strap;
            next_ctrl.common[`E1HMC_BIT_TX_CRC4] = strap_s.crc4_strap;
            next_ctrl.common[`E1HMC_BIT_RX_CRC4] = strap_s.crc4_strap;
            next_ctrl.tx_cfg[`E1HMC_BIT_CAS_OFF] = strap_s.cas_off_strap;
            next_ctrl.rx_cfg[`E1HMC_BIT_CAS_OFF] = strap_s.cas_off_strap;
        end
    end

    // reset clears control and forces resync indication until release
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl         <= '{default: `E1HMC_RST_CTRL};
            hw_mode      <= 1'b0;
            rx_sync_lost <= `E1HMC_RST_SYNC_LOST;
        end else begin
            ctrl         <= next_ctrl;
            hw_mode      <= next_hw_mode;
            rx_sync_lost <= next_sync_lost;
        end
    end

    // error counters keep their value through reset in host mode; hardware mode entry clears them; software presets them
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_err_cnt[i] = err_cnt[i];
            if (!hw_now && wb_wr && wb_idx == 4'(`E1HMC_IDX_BV_CNT + i)) begin
                next_err_cnt[i] = wb_dat_w[7:0];
            end
            if (ser_wr && ser_wr_word.addr == 4'(`E1HMC_IDX_BV_CNT + i)) begin
                next_err_cnt[i] = ser_wr_word.data;
            end
            if (hw_enter) begin
                next_err_cnt[i] = 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            err_cnt[i] <= next_err_cnt[i];
        end
    end
endmodule : e1hmc_top

// ===== tb/e1_hardware_mode_control_tb.sv
// e1_hardware_mode_control_tb: self-checking bench of e1hmc_top with a
// register model, a serial host model and both settings of the mode pin.
// assumes: the checker is bound from its own file.
module e1_hardware_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import e1hmc_pkg::*;

    logic         clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]   wb_adr, sr;
    logic [3:0]   wb_sel;
    logic [31:0]  wb_dat_w, wb_dat_r, rd;
    logic         sclk, cs_n, serial_in_line, serial_out_line, serial_out_oe;
    logic         host_port_select_n, resync_busy, rx_sync_lost, hw_mode;
    e1hmc_strap_t straps;
    e1hmc_ctrl_t  ctrl;
    logic [7:0]   m [0:8];
    int           err_count, tests_run, seed;

    e1hmc_top i_dut (
        .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .sclk(sclk), .cs_n(cs_n), .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
        .host_port_select_n(host_port_select_n), .straps(straps), .resync_busy(resync_busy),
        .ctrl(ctrl), .rx_sync_lost(rx_sync_lost), .hw_mode(hw_mode)
    );
    e1hmc_host_model i_host (
        .sclk(sclk), .cs_n(cs_n), .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // strap levels land on fixed control bits, every other bit stays clear
    function automatic logic [39:0] hw_exp(input logic [4:0] s);
        return {2'b00, s[4], 5'h00, 5'h00, s[3], 2'b00, 2'b00, {2{s[2]}}, {2{s[1]}},
                2'b00, 2'b00, s[0], 5'h00, 2'b00, s[0], 5'h00};
    endfunction : hw_exp

    task automatic wb_io(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_sel   <= 4'($random(seed)) | 4'h1;
        wb_dat_w <= {24'($random(seed)), d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20) check("ack wait", 40'h0, 40'h1);
        @(posedge clk);
    endtask : wb_io

    task automatic read_all(input string what);
        for (int i = 0; i < 9; i++) begin
            wb_io(1'b0, 8'(4 * i), 8'h00);
            check(what, rd, {24'h0, m[i]});
        end
    endtask : read_all

    task automatic do_reset(input logic sel_n);
        @(posedge clk);
        rst_n <= 1'b0;
        host_port_select_n <= sel_n;
        repeat (20) @(posedge clk);
        check("ctrl in reset", ctrl, 40'h0);
        check("sync lost in reset", rx_sync_lost, 1'b1);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : do_reset

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #500000;
        err_count++;
        finish_test();
    end

    initial begin
        seed = 43545;
        err_count = 0;
        tests_run = 0;
        // reset starts high so its first fall is seen by every flop but the error counters, which have no reset
        rst_n = 1'b1;
        {wb_cyc, wb_stb, wb_we, resync_busy} = '0;
        m = '{default: 8'h00};
        {wb_adr, wb_sel, wb_dat_w} = '0;
        straps = '0;
        host_port_select_n = 1'b1;
        do_reset(1'b1);
        // status is read-only, so the write of all ones must not stick
        for (int i = 0; i < 9; i++) begin
            m[i] = (i == 5) ? 8'h00 : 8'($random(seed));
            straps <= 5'($random(seed));
            wb_io(1'b1, 8'(4 * i), (i == 5) ? 8'hFF : m[i]);
            check("ctrl", ctrl, {m[0], m[1], m[2], m[3], m[4]});
        end
        wb_io(1'b1, 8'h40, 8'hFF);
        wb_io(1'b0, 8'h40, 8'h00);
        check("unmapped", {rd, ctrl[39:32]}, {32'h0, m[0]});
        wb_io(1'b0, 8'h24, 8'h00);
        check("unmapped", rd, 32'h0);
        read_all("read back");
        resync_busy <= 1'b1;
        wb_io(1'b0, 8'h14, 8'h00);
        check("status", rd, 32'h1);
        check("sync lost pin", rx_sync_lost, 1'b1);
        resync_busy <= 1'b0;
        $display("test register bus done");
        m[3] = 8'($random(seed));
        i_host.frame({8'h03, m[3]}, sr);
        check("serial write", ctrl, {m[0], m[1], m[2], m[3], m[4]});
        i_host.frame(16'h8600, sr);
        i_host.frame(16'h8600, sr);
        check("serial read", sr, m[6]);
        $display("test serial port done");
        do_reset(1'b1);
        for (int i = 0; i < 5; i++) m[i] = 8'h00;
        read_all("counters kept");
        $display("test reset done");
        do_reset(1'b0);
        check("hw mode", hw_mode, 1'b1);
        for (int s = 0; s < 32; s++) begin
            straps <= 5'(s);
            repeat (6) @(posedge clk);
            check("strap bits", ctrl, hw_exp(5'(s)));
        end
        resync_busy <= 1'b1;
        wb_io(1'b1, 8'h00, 8'h00);
        wb_io(1'b1, 8'h04, 8'hFF);
        {m[0], m[1], m[2], m[3], m[4]} = hw_exp(5'h1F);
        for (int i = 5; i < 9; i++) m[i] = 8'h00;
        read_all("hw regs");
        check("sync lost pin", rx_sync_lost, 1'b1);
        i_host.frame(16'h00FF, sr);
        check("serial off", ctrl, hw_exp(5'h1F));
        resync_busy <= 1'b0;
        $display("test hardware mode done");
        do_reset(1'b1);
        check("mode back", ctrl, 40'h0);
        check("hw mode off", hw_mode, 1'b0);
        $display("test mode exit done");
        finish_test();
    end
endmodule : e1_hardware_mode_control_tb

// ===== tb/e1hmc_checker.sv
// e1hmc_checker: concurrent checks on the ports of e1hmc_top.
// assumes: bound to e1hmc_top below; straps only change while reset or settled.
module e1hmc_checker
    import e1hmc_pkg::*;
(
    // clocks and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              sclk,
    // wishbone
    input  wire logic              wb_cyc,
    input  wire logic              wb_stb,
    input  wire logic              wb_ack,
    // serial pins
    input  wire logic              cs_n,
    input  wire logic              serial_out_oe,
    // mode pins and framer side
    input  e1hmc_pkg::e1hmc_strap_t straps,
    input  wire logic              resync_busy,
    input  e1hmc_pkg::e1hmc_ctrl_t  ctrl,
    input  wire logic              rx_sync_lost,
    input  wire logic              hw_mode
);
    import e1hmc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // five quiet cycles cover the strap synchronisers and the copy register
    sequence hw_settled;
        (hw_mode && $stable(straps)) [*5];
    endsequence

    a_ack_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property ($rose(wb_cyc && wb_stb) |=> wb_ack)
        else $error("request not answered after one cycle");
    a_far_alarm: assert property (
        hw_settled |-> ctrl.tx_insert[5] == straps.far_alarm_send_strap)
        else $error("remote alarm bit differs from strap");
    a_mf_alarm: assert property (
        hw_settled |-> ctrl.tx_extra[2] == straps.far_multiframe_alarm_strap)
        else $error("multiframe alarm bit differs from strap");
    a_line_code: assert property (
        hw_settled |-> ctrl.common[5:4] == {2{straps.line_code_strap}})
        else $error("coding bits differ from strap");
    a_crc4_bits: assert property (
        hw_settled |-> ctrl.common[3:2] == {2{straps.crc4_strap}})
        else $error("crc4 bits differ from strap");
    a_cas_bits: assert property (
        hw_settled |-> {ctrl.tx_cfg[5], ctrl.rx_cfg[5]} == {2{straps.cas_off_strap}})
        else $error("cas bits differ from strap");
    a_hw_cleared: assert property (
        hw_settled |-> (ctrl & ~40'h2004_3C20_20) == 40'h0)
        else $error("non-strap bit set in hardware mode");
    a_port_off: assert property (hw_mode |-> !serial_out_oe)
        else $error("serial output enabled in hardware mode");
    a_sync_pin: assert property (
        $past(rst_n, 3) |-> rx_sync_lost == $past(resync_busy))
        else $error("sync lost pin does not follow resync");
    a_reset_clear: assert property (disable iff (1'b0)
        !rst_n |-> ctrl == 40'h0 && rx_sync_lost)
        else $error("reset left control bits or sync flag wrong");
    a_oe_framed: assert property (@(posedge sclk) disable iff (!rst_n)
        serial_out_oe |-> !cs_n)
        else $error("serial output enabled outside a frame");

    c_hw: cover property (hw_settled);
    c_serial_rd: cover property ($rose(serial_out_oe));
    c_ack: cover property (wb_ack);
endmodule : e1hmc_checker

bind e1hmc_top e1hmc_checker i_chk (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_ack(wb_ack), .cs_n(cs_n), .serial_out_oe(serial_out_oe), .straps(straps),
    .resync_busy(resync_busy), .ctrl(ctrl), .rx_sync_lost(rx_sync_lost), .hw_mode(hw_mode)
);

// ===== tb/e1hmc_host_model.sv
// e1hmc_host_model: host that drives the serial control port in 16-bit frames.
// assumes: one frame() at a time; the serial clock only runs in and just before frames.
module e1hmc_host_model (
    // serial pins toward the device
    output logic      sclk,
    output logic      cs_n,
    output logic      serial_in_line,
    input  wire logic serial_out_line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in_line = 1'b1;
    end

    // a read is a read-address frame followed by a frame that carries the data
    task automatic frame(input logic [15:0] w, output logic [7:0] r);
        r = 8'h00;
        // idle edges with cs_n high let the port's reset and select cross first
        repeat (4) begin
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        #3 cs_n = 1'b0;
        for (int k = 15; k >= 0; k--) begin
            serial_in_line = w[k];
            #31;
            if (k < 8) r[k] = serial_out_line;
            #1 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        // released line shows the inverse, so stale data never looks valid
        serial_in_line = ~serial_in_line;
        #1100;
    endtask : frame
endmodule : e1hmc_host_model
